// ==== rtl/iom_register_map.sv ====
// Top of the memory-mapped I/O register space: decode, storage, reads.
// Assumes the core drives one access per cycle, synchronous to mclk_i,
// and takes read data and bit-test results one cycle later.
//
// How it works
// - Bit set/clear at I/O 0x00-0x1F.
// - Bit test for skip instructions there.
// - Writing one clears status flags.
// - Bit ops touch only the addressed bit.
// - I/O instructions use 64-location window.
// - Load/store sees I/O address plus 0x20.
// - Extended 0x60-0xFF only by load/store.
`timescale 1ns/1ps
`default_nettype none
module iom_register_map
  import iom_pkg::*;
(
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 resetn_i,
  // I/O instruction path
  input  wire logic                 io_rd_i,
  input  wire logic                 io_wr_i,
  input  wire logic [5:0]           io_addr_i,
  input  wire logic [7:0]           io_wdata_i,
  // Load/store path
  input  wire logic                 ds_rd_i,
  input  wire logic                 ds_wr_i,
  input  wire logic [7:0]           ds_addr_i,
  input  wire logic [7:0]           ds_wdata_i,
  // Bit instruction path
  input  wire logic                 bit_set_i,
  input  wire logic                 bit_clr_i,
  input  wire logic                 bit_test_i,
  input  wire logic [4:0]           bit_addr_i,
  input  wire logic [2:0]           bit_sel_i,
  // Peripheral side
  input  wire logic [7:0]           pin_b_i,
  input  wire logic [7:0]           pin_c_i,
  input  wire logic [7:0]           pin_d_i,
  input  wire logic [NREG-1:0][7:0] flag_event_i,
  // Answers to the core
  output logic      [7:0]           rdata_o,
  output logic                      rd_valid_o,
  output logic                      bit_value_o,
  output logic                      test_valid_o,
  output logic                      access_miss_o,
  // Register contents to the peripherals
  output logic      [NREG-1:0][7:0] reg_value_o
);

  logic             rst_meta;
  logic             rst_n;
  logic [7:0]       acc_addr;
  logic             acc_rd;
  logic             acc_wr;
  logic             acc_test;
  logic [7:0]       acc_wmask;
  logic [7:0]       acc_wval;
  logic [2:0]       acc_bit;
  logic [NREG-1:0]  hit;
  logic [7:0]       reg_rdata [NREG];
  logic [7:0]       rd_chain  [NREG+1];
  logic [7:0]       rd_word;
  logic             acc_any;
  logic             any_hit;

  // Reset released through two flops; asserted at once
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Three instruction paths folded into one data-space access
  iom_access_decode u_decode (
    .io_rd_i     (io_rd_i),
    .io_wr_i     (io_wr_i),
    .io_addr_i   (io_addr_i),
    .io_wdata_i  (io_wdata_i),
    .ds_rd_i     (ds_rd_i),
    .ds_wr_i     (ds_wr_i),
    .ds_addr_i   (ds_addr_i),
    .ds_wdata_i  (ds_wdata_i),
    .bit_set_i   (bit_set_i),
    .bit_clr_i   (bit_clr_i),
    .bit_test_i  (bit_test_i),
    .bit_addr_i  (bit_addr_i),
    .bit_sel_i   (bit_sel_i),
    .acc_addr_o  (acc_addr),
    .acc_rd_o    (acc_rd),
    .acc_wr_o    (acc_wr),
    .acc_test_o  (acc_test),
    .acc_wmask_o (acc_wmask),
    .acc_wval_o  (acc_wval),
    .acc_bit_o   (acc_bit)
  );

  assign rd_chain[0] = BYTE_ZERO;

  // One register per table entry; reserved addresses match none
  generate
    for (genvar i = 0; i < NREG; i++) begin : g_reg
      localparam logic [7:0] PMASK =
        (i == IDX_PB_PIN || i == IDX_PD_PIN) ? BYTE_ALL :
        (i == IDX_PC_PIN) ? REG_VALID[IDX_PC_PIN] : BYTE_ZERO;
      logic [7:0] pin_word;

      assign hit[i]   = (acc_addr == REG_ADDR[i]);
      assign pin_word = (i == IDX_PB_PIN) ? pin_b_i :
                        (i == IDX_PC_PIN) ? pin_c_i :
                        (i == IDX_PD_PIN) ? pin_d_i : BYTE_ZERO;

      iom_byte_reg #(
        .VALID_MASK (REG_VALID[i]),
        .W1C_MASK   (REG_W1C[i]),
        .PIN_MASK   (PMASK)
      ) u_reg (
        .clk_i   (mclk_i),
        .rst_n_i (rst_n),
        .sel_i   (hit[i] & acc_wr),
        .wmask_i (acc_wmask),
        .wval_i  (acc_wval),
        .event_i (flag_event_i[i]),
        .pin_i   (pin_word),
        .store_o (reg_value_o[i]),
        .rdata_o (reg_rdata[i])
      );

      // Read mux as an OR chain; at most one entry hits
      assign rd_chain[i+1] = rd_chain[i] | (hit[i] ? reg_rdata[i] : BYTE_ZERO);
    end
  endgenerate

  // Unmapped reads fall out of the chain as zero
  assign rd_word = rd_chain[NREG];
  assign acc_any = acc_rd | acc_wr | acc_test;
  assign any_hit = |hit;

  // Answers are registered so the core sees them one cycle later
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o       <= BYTE_ZERO;
      rd_valid_o    <= 1'b0;
      bit_value_o   <= 1'b0;
      test_valid_o  <= 1'b0;
      access_miss_o <= 1'b0;
    end else begin
      rd_valid_o    <= acc_rd;
      test_valid_o  <= acc_test;
      access_miss_o <= acc_any & ~any_hit;
      if (acc_rd) begin
        rdata_o <= rd_word;
      end
      if (acc_test) begin
        bit_value_o <= rd_word[acc_bit];
      end
    end
  end

  // Checks
  localparam logic [5:0] IO_PB_OUT = 6'(REG_ADDR[IDX_PB_OUT] - IO_DS_OFFSET);
  localparam logic [4:0] BIT_PB_DIR = 5'(REG_ADDR[IDX_PB_DIR] - IO_DS_OFFSET);
  localparam logic [4:0] BIT_PB_PIN = 5'(REG_ADDR[IDX_PB_PIN] - IO_DS_OFFSET);
  localparam logic [5:0] IO_T0_FLG = 6'(REG_ADDR[IDX_T0_FLAGS] - IO_DS_OFFSET);

  logic       io_any;
  logic       ds_any;
  logic       bit_only;
  logic       port_b_pin_input_expect;
  logic [7:0] keep_mask;

  // Helper terms for the checks only
  assign io_any      = io_rd_i | io_wr_i;
  assign ds_any      = ds_rd_i | ds_wr_i;
  assign bit_only    = ~io_any & ~ds_any;
  assign port_b_pin_input_expect = pin_b_i[bit_sel_i];
  assign keep_mask   = ~(BYTE_ONE << bit_sel_i);

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  property p_io_alias;
    io_wr_i && io_addr_i == IO_PB_OUT
    |=> reg_value_o[IDX_PB_OUT] == $past(io_wdata_i);
  endproperty
  a_io_alias: assert property (p_io_alias)
    else $error("I/O write missed its register");

  property p_ds_alias;
    !io_any && ds_wr_i && ds_addr_i == REG_ADDR[IDX_PB_OUT]
    |=> reg_value_o[IDX_PB_OUT] == $past(ds_wdata_i);
  endproperty
  a_ds_alias: assert property (p_ds_alias)
    else $error("Store at I/O address plus offset missed");

  property p_ext_only;
    io_wr_i |=> $stable(reg_value_o[IDX_CLK_PRESC]);
  endproperty
  a_ext_only: assert property (p_ext_only)
    else $error("I/O write reached the extended region");

  property p_w1c;
    io_wr_i && io_addr_i == IO_T0_FLG && io_wdata_i[1]
    && !flag_event_i[IDX_T0_FLAGS][1]
    |=> !reg_value_o[IDX_T0_FLAGS][1];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("Flag not cleared by writing one");

  property p_event_wins;
    flag_event_i[IDX_T0_FLAGS][0] |=> reg_value_o[IDX_T0_FLAGS][0] ##1
    (reg_value_o[IDX_T0_FLAGS][0] || $past(acc_wr));
  endproperty
  a_event_wins: assert property (p_event_wins)
    else $error("Flag event lost");

  property p_bit_set;
    bit_only && bit_set_i && bit_addr_i == BIT_PB_DIR
    |=> reg_value_o[IDX_PB_DIR][$past(bit_sel_i)];
  endproperty
  a_bit_set: assert property (p_bit_set)
    else $error("Bit set did not take effect");

  property p_bit_only;
    bit_only && (bit_set_i || bit_clr_i) && bit_addr_i == BIT_PB_DIR
    |=> ((reg_value_o[IDX_PB_DIR] ^ $past(reg_value_o[IDX_PB_DIR]))
         & $past(keep_mask)) == BYTE_ZERO;
  endproperty
  a_bit_only: assert property (p_bit_only)
    else $error("Bit op disturbed another bit");

  property p_bit_test;
    bit_only && bit_test_i && !bit_set_i && !bit_clr_i
    && bit_addr_i == BIT_PB_PIN
    |=> test_valid_o && bit_value_o == $past(port_b_pin_input_expect);
  endproperty
  a_bit_test: assert property (p_bit_test)
    else $error("Bit test returned wrong value");

  property p_rsv_zero;
    io_rd_i && !io_wr_i && io_addr_i == IO_RSV_ADDR
    |=> rd_valid_o && rdata_o == BYTE_ZERO && access_miss_o;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("Reserved address read not zero");

  property p_rd_latency;
    (io_rd_i && !io_wr_i) |=> rd_valid_o ##1 (rd_valid_o == $past(acc_rd));
  endproperty
  a_rd_latency: assert property (p_rd_latency)
    else $error("Read answer not one cycle later");

  c_w1c_clear: cover property (io_wr_i && io_addr_i == IO_T0_FLG ##1
                               !reg_value_o[IDX_T0_FLAGS][1]);
  c_bit_test:  cover property (bit_only && bit_test_i ##1 bit_value_o);
  c_ds_ext:    cover property (ds_wr_i && !io_any && ds_addr_i >= EXT_BASE);
  c_miss:      cover property (access_miss_o);

endmodule
`default_nettype wire

// ==== rtl/iom_pkg.sv ====
// Constants for the memory-mapped I/O register space.
// Assumes an 8-bit data space in which the I/O window sits at data
// address 0x20 and the extended region at 0x60 and above.
package iom_pkg;

  localparam int          NREG         = 48;
  localparam logic [7:0]  IO_DS_OFFSET = 8'h20;  // I/O address to data address
  localparam logic [7:0]  EXT_BASE     = 8'h60;  // First load/store-only address
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [7:0]  BYTE_ALL     = 8'hFF;
  localparam logic [7:0]  BYTE_ONE     = 8'h01;
  localparam logic [7:0]  RESET_VAL    = 8'h00;  // Contents after reset
  localparam logic [5:0]  IO_RSV_ADDR  = 6'h00;  // A reserved I/O location

  // Data-space address of each implemented register, in table order
  localparam logic [7:0] REG_ADDR [NREG] = '{
    8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2A,
    8'h2B, 8'h35, 8'h36, 8'h37, 8'h3B, 8'h3C, 8'h3D, 8'h3F,
    8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47,
    8'h48, 8'h4A, 8'h4B, 8'h4C, 8'h4D, 8'h4E, 8'h50, 8'h53,
    8'h54, 8'h55, 8'h57, 8'h5D, 8'h5E, 8'h5F, 8'h60, 8'h61,
    8'h64, 8'h66, 8'h68, 8'h69, 8'h6B, 8'h6C, 8'h6D, 8'h6E};

  // Implemented bits; all others are reserved and read zero
  localparam logic [7:0] REG_VALID [NREG] = '{
    8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h7F, 8'h7F, 8'hFF, 8'hFF,
    8'hFF, 8'h07, 8'h27, 8'h07, 8'h07, 8'h03, 8'h03, 8'h3F,
    8'hFF, 8'hFF, 8'hFF, 8'h83, 8'hF3, 8'hCF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hC1, 8'hFF, 8'hFF, 8'h0F,
    8'h0F, 8'h73, 8'hDF, 8'hFF, 8'h07, 8'hFF, 8'hFF, 8'h8F,
    8'hEF, 8'hFF, 8'h07, 8'h0F, 8'hFF, 8'h7F, 8'hFF, 8'h07};

  // Status flags set by hardware and cleared by writing one
  localparam logic [7:0] REG_W1C [NREG] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h07, 8'h27, 8'h07, 8'h07, 8'h03, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'hC0, 8'h00, 8'h10, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // Table indices used by the logic and its checks
  localparam int IDX_PB_PIN    = 0;
  localparam int IDX_PB_DIR    = 1;
  localparam int IDX_PB_OUT    = 2;
  localparam int IDX_PC_PIN    = 3;
  localparam int IDX_PD_PIN    = 6;
  localparam int IDX_T0_FLAGS  = 9;
  localparam int IDX_CLK_PRESC = 39;

endpackage

// ==== rtl/iom_byte_reg.sv ====
// One 8-bit register of the I/O space with plain, flag and pin bits.
// Assumes one decoded access per cycle, already reduced to a bit mask
// and a value by the access decoder.
`timescale 1ns/1ps
`default_nettype none
module iom_byte_reg
  import iom_pkg::*;
#(
  parameter logic [7:0] VALID_MASK = BYTE_ALL,
  parameter logic [7:0] W1C_MASK   = BYTE_ZERO,
  parameter logic [7:0] PIN_MASK   = BYTE_ZERO
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Decoded write
  input  wire logic       sel_i,
  input  wire logic [7:0] wmask_i,
  input  wire logic [7:0] wval_i,
  // Hardware side
  input  wire logic [7:0] event_i,
  input  wire logic [7:0] pin_i,
  // Contents
  output logic      [7:0] store_o,
  output logic      [7:0] rdata_o
);

  localparam logic [7:0] RW_MASK = VALID_MASK & ~W1C_MASK & ~PIN_MASK;

  logic [7:0] wr_bits;
  logic [7:0] clr_bits;
  logic [7:0] next_store;

  // Only bits named by the mask move, so a single-bit op spares flags
  assign wr_bits    = sel_i ? (wmask_i & RW_MASK) : BYTE_ZERO;
  assign clr_bits   = sel_i ? (wmask_i & wval_i & W1C_MASK) : BYTE_ZERO;
  // Hardware set outranks a clear in the same cycle, so no event is lost
  assign next_store = (((store_o & ~wr_bits) | (wval_i & wr_bits))
                       & ~clr_bits) | (event_i & W1C_MASK);
  // Pins read live; reserved bits always read zero
  assign rdata_o    = ((store_o & ~PIN_MASK) | (pin_i & PIN_MASK))
                      & VALID_MASK;

  // Storage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      store_o <= RESET_VAL;
    end else begin
      store_o <= next_store;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/iom_access_decode.sv ====
// Turns the three instruction access paths into one data-space access.
// Assumes the core presents at most one path at a time; if not, the
// I/O path wins, then load/store, then the bit path.
`timescale 1ns/1ps
`default_nettype none
module iom_access_decode
  import iom_pkg::*;
(
  // I/O instruction path
  input  wire logic       io_rd_i,
  input  wire logic       io_wr_i,
  input  wire logic [5:0] io_addr_i,
  input  wire logic [7:0] io_wdata_i,
  // Load/store path
  input  wire logic       ds_rd_i,
  input  wire logic       ds_wr_i,
  input  wire logic [7:0] ds_addr_i,
  input  wire logic [7:0] ds_wdata_i,
  // Bit instruction path
  input  wire logic       bit_set_i,
  input  wire logic       bit_clr_i,
  input  wire logic       bit_test_i,
  input  wire logic [4:0] bit_addr_i,
  input  wire logic [2:0] bit_sel_i,
  // Unified access
  output logic      [7:0] acc_addr_o,
  output logic            acc_rd_o,
  output logic            acc_wr_o,
  output logic            acc_test_o,
  output logic      [7:0] acc_wmask_o,
  output logic      [7:0] acc_wval_o,
  output logic      [2:0] acc_bit_o
);

  logic       io_req;
  logic       ds_req;
  logic       bit_req;
  logic       bit_mod;
  logic [7:0] io_daddr;
  logic [7:0] bit_daddr;
  logic [7:0] bit_onehot;

  // Path arbitration
  assign io_req  = io_rd_i | io_wr_i;
  assign ds_req  = ~io_req & (ds_rd_i | ds_wr_i);
  assign bit_req = ~io_req & ~ds_req & (bit_set_i | bit_clr_i | bit_test_i);
  assign bit_mod = bit_set_i | bit_clr_i;

  // Six-bit window lifted into data space; never reaches 0x60
  assign io_daddr   = {2'b00, io_addr_i} + IO_DS_OFFSET;
  // Five-bit field limits bit ops to the low 32 I/O locations
  assign bit_daddr  = {3'b000, bit_addr_i} + IO_DS_OFFSET;
  assign bit_onehot = BYTE_ONE << bit_sel_i;

  // Unified request
  assign acc_addr_o  = io_req ? io_daddr : (ds_req ? ds_addr_i : bit_daddr);
  assign acc_wr_o    = (io_req & io_wr_i) | (ds_req & ds_wr_i)
                       | (bit_req & bit_mod);
  assign acc_rd_o    = (io_req & ~io_wr_i) | (ds_req & ~ds_wr_i);
  assign acc_test_o  = bit_req & ~bit_mod;
  assign acc_wmask_o = bit_req ? bit_onehot : BYTE_ALL;
  // Set wins over clear when both arrive
  assign acc_wval_o  = io_req ? io_wdata_i :
                       (ds_req ? ds_wdata_i :
                        (bit_set_i ? BYTE_ALL : BYTE_ZERO));
  assign acc_bit_o   = bit_sel_i;

endmodule
`default_nettype wire

// ==== dv/iom_core_model.sv ====
// Model of the processor core issuing I/O, load/store and bit accesses.
// Assumes the register map takes a request at the edge after it is
// raised and answers in the cycle after that edge.
`timescale 1ns/1ps
`default_nettype none
module iom_core_model
  import iom_pkg::*;
(
  // Clock
  input  wire logic       clk_i,
  // I/O instruction path
  output var  logic       io_rd_o,
  output var  logic       io_wr_o,
  output var  logic [5:0] io_addr_o,
  output var  logic [7:0] io_wdata_o,
  // Load/store path
  output var  logic       ds_rd_o,
  output var  logic       ds_wr_o,
  output var  logic [7:0] ds_addr_o,
  output var  logic [7:0] ds_wdata_o,
  // Bit instruction path
  output var  logic       bit_set_o,
  output var  logic       bit_clr_o,
  output var  logic       bit_test_o,
  output var  logic [4:0] bit_addr_o,
  output var  logic [2:0] bit_sel_o,
  // Answers
  input  wire logic [7:0] rdata_i,
  input  wire logic       rd_valid_i,
  input  wire logic       bit_value_i,
  input  wire logic       test_valid_i,
  input  wire logic       access_miss_i
);
  // Idle at time zero
  initial begin
    {io_rd_o, io_wr_o, ds_rd_o, ds_wr_o} = '0;
    {bit_set_o, bit_clr_o, bit_test_o} = '0;
    {io_addr_o, io_wdata_o, ds_addr_o, ds_wdata_o} = '0;
    {bit_addr_o, bit_sel_o} = '0;
  end

  // One I/O access; callers write mapped places with reserved bits zero
  task automatic io_acc(input logic w, input logic [5:0] a,
                        input logic [7:0] d, output logic [7:0] q,
                        output logic v, output logic m);
    @(posedge clk_i);
    io_wr_o <= w;
    io_rd_o <= !w;
    io_addr_o <= a;
    io_wdata_o <= d;
    @(posedge clk_i);
    {io_wr_o, io_rd_o} <= 2'b00;
    io_addr_o <= ~a;  // Released lines do not keep the old value
    io_wdata_o <= ~d;
    #1;
    {q, v, m} = {rdata_i, rd_valid_i, access_miss_i};
  endtask

  // One load or store; same discipline on reserved places
  task automatic ds_acc(input logic w, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q,
                        output logic v, output logic m);
    @(posedge clk_i);
    ds_wr_o <= w;
    ds_rd_o <= !w;
    ds_addr_o <= a;
    ds_wdata_o <= d;
    @(posedge clk_i);
    {ds_wr_o, ds_rd_o} <= 2'b00;
    ds_addr_o <= ~a;
    ds_wdata_o <= ~d;
    #1;
    {q, v, m} = {rdata_i, rd_valid_i, access_miss_i};
  endtask

  // Bit instruction; k is one-hot {set, clear, test}
  task automatic bit_op(input logic [2:0] k, input logic [4:0] a,
                        input logic [2:0] s, output logic b,
                        output logic v);
    @(posedge clk_i);
    {bit_set_o, bit_clr_o, bit_test_o} <= k;
    bit_addr_o <= a;
    bit_sel_o <= s;
    @(posedge clk_i);
    {bit_set_o, bit_clr_o, bit_test_o} <= 3'b000;
    bit_addr_o <= ~a;
    bit_sel_o <= ~s;
    #1;
    {b, v} = {bit_value_i, test_valid_i};
  endtask
endmodule
`default_nettype wire

// ==== dv/iom_register_map_tb_top.sv ====
// Self-checking bench for the I/O register space.
// Assumes the core model drives all requests; pins and flag events
// are driven here; pins are fixed from time zero, flag events change at the rising edge.
`timescale 1ns/1ps
`default_nettype none
module iom_register_map_tb_top;
  import iom_pkg::*;
  logic mclk_i, resetn_i;
  logic io_rd_i, io_wr_i, ds_rd_i, ds_wr_i;
  logic bit_set_i, bit_clr_i, bit_test_i, bit_value_o, test_valid_o;
  logic [5:0] io_addr_i;
  logic [4:0] bit_addr_i;
  logic [2:0] bit_sel_i;
  logic [7:0] io_wdata_i, ds_addr_i, ds_wdata_i, pin_b_i, pin_c_i;
  logic [7:0] pin_d_i, rdata_o;
  logic rd_valid_o, access_miss_o;
  logic [NREG-1:0][7:0] flag_event_i, reg_value_o;
  int n_mismatch, cmp_count;
  logic [7:0] q;
  logic v, m;

  // Clock, 8 ns period
  initial mclk_i = 1'b0;
  always #4 mclk_i = ~mclk_i;

  iom_core_model i_core (.clk_i(mclk_i),
    .io_rd_o(io_rd_i), .io_wr_o(io_wr_i), .io_addr_o(io_addr_i),
    .io_wdata_o(io_wdata_i), .ds_rd_o(ds_rd_i), .ds_wr_o(ds_wr_i),
    .ds_addr_o(ds_addr_i), .ds_wdata_o(ds_wdata_i),
    .bit_set_o(bit_set_i), .bit_clr_o(bit_clr_i),
    .bit_test_o(bit_test_i), .bit_addr_o(bit_addr_i),
    .bit_sel_o(bit_sel_i), .rdata_i(rdata_o), .rd_valid_i(rd_valid_o),
    .bit_value_i(bit_value_o), .test_valid_i(test_valid_o),
    .access_miss_i(access_miss_o));

  iom_register_map i_dut (.mclk_i, .resetn_i, .io_rd_i, .io_wr_i,
    .io_addr_i, .io_wdata_i, .ds_rd_i, .ds_wr_i, .ds_addr_i,
    .ds_wdata_i, .bit_set_i, .bit_clr_i, .bit_test_i, .bit_addr_i,
    .bit_sel_i, .pin_b_i, .pin_c_i, .pin_d_i, .flag_event_i, .rdata_o,
    .rd_valid_o, .bit_value_o, .test_valid_o, .access_miss_o,
    .reg_value_o);

  // Comparisons by kind of result
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_byte({7'h00, got}, {7'h00, exp});
  endtask

  // Reads with an expected value and miss flag; bit op with no check of its own
  task automatic ds_rd(input logic [7:0] a, input logic [7:0] e,
                       input logic em);
    i_core.ds_acc(1'b0, a, 8'h00, q, v, m);
    cmp_byte(q, e);
    cmp_bit(v, 1'b1);
    cmp_bit(m, em);
  endtask
  task automatic io_rd(input logic [5:0] a, input logic [7:0] e,
                       input logic em);
    i_core.io_acc(1'b0, a, 8'h00, q, v, m);
    cmp_byte(q, e);
    cmp_bit(v, 1'b1);
    cmp_bit(m, em);
  endtask
  task automatic bit_do(input logic [2:0] k, input logic [4:0] a,
                        input logic [2:0] s);
    i_core.bit_op(k, a, s, m, v);
  endtask

  // Contents after reset
  task automatic t_reset();
    for (int i = 0; i < NREG; i++) cmp_byte(reg_value_o[i], RESET_VAL);
    $display("test reset done");
  endtask

  // Same register through the I/O window and through data space
  task automatic t_window();
    i_core.io_acc(1'b1, 6'h05, 8'hA5, q, v, m);
    ds_rd(8'h25, 8'hA5, 1'b0);
    cmp_byte(reg_value_o[IDX_PB_OUT], 8'hA5);
    i_core.ds_acc(1'b1, 8'h25, 8'h5A, q, v, m);
    io_rd(6'h05, 8'h5A, 1'b0);
    i_core.ds_acc(1'b1, 8'h2B, 8'h3C, q, v, m);
    io_rd(6'h0B, 8'h3C, 1'b0);
    i_core.io_acc(1'b1, 6'h3F, 8'h81, q, v, m);
    ds_rd(8'h5F, 8'h81, 1'b0);
    io_rd(6'h09, 8'h3C, 1'b0);
    $display("test window done");
  endtask

  // Extended region by load/store; I/O top does not alias into it
  task automatic t_ext();
    i_core.ds_acc(1'b1, 8'h66, 8'h5A, q, v, m);
    ds_rd(8'h66, 8'h5A, 1'b0);
    i_core.io_acc(1'b1, 6'h26, 8'h11, q, v, m);
    cmp_byte(reg_value_o[41], 8'h5A);
    cmp_byte(reg_value_o[22], 8'h11);
    $display("test ext done");
  endtask

  // Bit set and test over every bit position, clear over the even ones
  task automatic t_bit();
    logic [7:0] e;
    e = 8'h00;
    i_core.io_acc(1'b1, 6'h04, 8'h00, q, v, m);
    for (int s = 0; s < 8; s++) begin
      bit_do(3'b100, 5'h04, 3'(s));
      e[s] = 1'b1;
      cmp_byte(reg_value_o[IDX_PB_DIR], e);
    end
    for (int s = 0; s < 8; s += 2) begin
      bit_do(3'b010, 5'h04, 3'(s));
      e[s] = 1'b0;
      cmp_byte(reg_value_o[IDX_PB_DIR], e);
    end
    for (int s = 0; s < 8; s++) begin
      bit_do(3'b001, 5'h03, 3'(s));
      cmp_bit(m, pin_b_i[s]);
      cmp_bit(v, 1'b1);
      bit_do(3'b001, 5'h04, 3'(s));
      cmp_bit(m, e[s]);
    end
    $display("test bit done");
  endtask

  // Write-one-clear flags beside bit operations
  task automatic t_flags();
    @(posedge mclk_i);
    flag_event_i[IDX_T0_FLAGS] <= 8'h07;
    @(posedge mclk_i);
    flag_event_i[IDX_T0_FLAGS] <= 8'h00;
    io_rd(6'h15, 8'h07, 1'b0);
    i_core.io_acc(1'b1, 6'h15, 8'h02, q, v, m);
    io_rd(6'h15, 8'h05, 1'b0);
    bit_do(3'b100, 5'h15, 3'd0);
    io_rd(6'h15, 8'h04, 1'b0);
    bit_do(3'b010, 5'h15, 3'd2);
    io_rd(6'h15, 8'h04, 1'b0);
    $display("test flags done");
  endtask

  // Reserved places and bits read zero
  task automatic t_reserved();
    logic [7:0] adr [5] = '{8'h00, 8'h20, 8'h2C, 8'h6A, 8'hFF};
    foreach (adr[i]) ds_rd(adr[i], 8'h00, 1'b1);
    io_rd(IO_RSV_ADDR, 8'h00, 1'b1);
    ds_rd(8'h26, 8'h7F, 1'b0);
    i_core.io_acc(1'b1, 6'h03, 8'h5A, q, v, m);
    cmp_byte(reg_value_o[IDX_PB_PIN], 8'h00);
    $display("test reserved done");
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_mismatch++;
    summarize();
  end

  // Main sequence
  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    resetn_i = 1'b0;
    flag_event_i = '0;
    pin_b_i = 8'hA5;
    pin_c_i = 8'hFF;
    pin_d_i = 8'h3C;
    repeat (20) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    #1;
    t_reset();
    t_window();
    t_ext();
    t_bit();
    t_flags();
    t_reserved();
    summarize();
  end
endmodule
`default_nettype wire
